/* rtl/pir_params.svh */
`ifndef PIR_PARAMS_SVH
`define PIR_PARAMS_SVH

// ==========================================================
// register offsets (global, independent of page)
`define PIR_OFS_INT_MASK     8'hF0
`define PIR_OFS_INT_FLAGS    8'hF1
`define PIR_OFS_PAGE_SEL     8'hFD
`define PIR_OFS_PAGE_UNLOCK  8'hFE

// ==========================================================
// reset values and key values
`define PIR_RST_INT_MASK     4'h0
`define PIR_RST_INT_FLAGS    5'h00
`define PIR_RST_PAGE_SEL     2'h0
`define PIR_RST_PAGE_UNLOCK  8'h00
`define PIR_UNLOCK_KEY       8'hC5
`define PIR_PAGE_MAX         8'h03

// ==========================================================
// device address: fixed upper bits, straps below
`define PIR_ADDR_TOP         3'h5

// ==========================================================
// readable page windows
`define PIR_PG_LED           2'h0
`define PIR_PG_FUNC          2'h3
`define PIR_LED_RD_FIRST     8'h18
`define PIR_LED_RD_LAST      8'h47
`define PIR_FUNC_RESET_OFS   8'h11

// ==========================================================
// mask bit positions
`define PIR_MASK_OPEN        0
`define PIR_MASK_SHORT       1
`define PIR_MASK_BREATH      2
`define PIR_MASK_SELF_CLR    3

// ==========================================================
// timing
`define PIR_CLK_PERIOD_NS    20
`define PIR_SELF_CLR_MS      8
`define PIR_NS_PER_MS        1000000

`endif

/* rtl/pir_pkg.sv */
`default_nettype none
package pir_pkg;

	// protocol engine states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_RACK = 5'h10
	} pir_state_t;

	// write toward the paged register banks
	typedef struct packed {
		logic       valid;
		logic [1:0] page;
		logic [7:0] addr;
		logic [7:0] data;
	} pir_wr_t;

	// read address toward the paged register banks
	typedef struct packed {
		logic [1:0] page;
		logic [7:0] addr;
	} pir_rd_t;

	// event pulses from the led core
	typedef struct packed {
		logic [2:0] breath_done;
		logic       short_ev;
		logic       open_ev;
	} pir_evt_t;

endpackage
`default_nettype wire

/* rtl/pir_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pir_params.svh"

// What this block does
// - address byte holds 7-bit address above a direction bit, 0 write, 1 read.
// - address is 101, then high strap code, then low strap code.
// - data sampled while clock high; master keeps data high when idle.
// - start is data falling with clock high; stop is data rising, ends transfer.
// - acknowledge address on ninth pulse only when it matches ours.
// - first byte after write address is the register pointer, acknowledged.
// - each following data byte is acknowledged and stored at the pointer.
// - pointer advances by one during each data acknowledge.
// - only unlock, status, led page 18h-47h and function page 11h read back.
// - read is write pointer, repeated start with read bit, then shift out.
// - page select register picks page 0 to 3; other values reserved; resets 0.
// - ordinary writes land in the currently selected page.
// - page select ignores writes unless the unlock register holds the key.
// - key allows one page select write, then unlock returns to zero.
// - mask register enables open, short, breath finish and self clear.
// - with self clear, interrupt clears after being low over 8 ms.
// - status register flags open, short and three breath finishes.
module pir_port #(
	parameter int unsigned SELF_CLR_CYCLES =
		`PIR_SELF_CLR_MS * `PIR_NS_PER_MS / `PIR_CLK_PERIOD_NS
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              link_scl,
	input  wire logic              sda_in,
	output var  logic              sda_out,
	output var  logic              sda_oe_n,
	input  wire logic [1:0]        address_strap_low,
	input  wire logic [1:0]        address_strap_high,
	input  wire pir_pkg::pir_evt_t led_events,
	input  wire logic [7:0]        page_rd_data,
	output var  pir_pkg::pir_rd_t  page_rd,
	output var  pir_pkg::pir_wr_t  page_wr,
	output var  logic              interrupt_out_n
);

	// ==========================================================
	// link clock domain

	logic sda_at_rise;

	// data taken on the bus clock's rising edge; held for the core to read
	always_ff @(posedge link_scl) begin
		sda_at_rise <= sda_in;
	end

	// ==========================================================
	// pin synchronisers

	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] rbit_sync;
	logic [1:0] strap_lo_m;
	logic [1:0] strap_lo_s;
	logic [1:0] strap_hi_m;
	logic [1:0] strap_hi_s;
	logic       scl_d;
	logic       sda_d;
	logic [1:0] rise_q;

	// two flops per pin before any logic looks at them
	always_ff @(posedge core_clk) begin
		scl_sync   <= {scl_sync[0], link_scl};
		sda_sync   <= {sda_sync[0], sda_in};
		rbit_sync  <= {rbit_sync[0], sda_at_rise};
		strap_lo_m <= address_strap_low;
		strap_lo_s <= strap_lo_m;
		strap_hi_m <= address_strap_high;
		strap_hi_s <= strap_hi_m;
	end

	// delayed copies for edge detection
	always_ff @(posedge core_clk) begin
		if (reset) begin
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
			rise_q <= 2'h0;
		end else begin
			scl_d  <= scl_sync[1];
			sda_d  <= sda_sync[1];
			rise_q <= {rise_q[0], scl_sync[1] & ~scl_d};
		end
	end

	logic start_ev;
	logic stop_ev;
	logic bit_ev;
	logic fall_ev;
	logic rx_bit;

	// start and stop are data edges while the clock stays high
	assign start_ev = scl_sync[1] & scl_d & ~sda_sync[1] & sda_d;
	assign stop_ev  = scl_sync[1] & scl_d & sda_sync[1] & ~sda_d;
	// bit taken two cycles late so the captured level has crossed over
	assign bit_ev   = rise_q[1];
	assign fall_ev  = ~scl_sync[1] & scl_d;
	assign rx_bit   = rbit_sync[1];

	// ==========================================================
	// registers

	pir_pkg::pir_state_t state_reg;
	logic [3:0]          cnt_reg;
	logic [7:0]          rx_reg;
	logic [7:0]          tx_reg;
	logic                is_addr_reg;
	logic                have_ptr_reg;
	logic                read_dir_reg;
	logic                mack_reg;
	logic [7:0]          ptr_reg;
	logic [1:0]          page_reg;
	logic [7:0]          unlock_reg;
	logic [3:0]          mask_reg;
	logic [4:0]          flags_reg;
	logic                soft_rst_reg;
	logic [31:0]         low_cnt_reg;

	logic       reg_rst;
	logic       byte_done;
	logic       addr_hit;
	logic       accept;
	logic       wr_data_ev;
	logic       ptr_load_ev;
	logic       tx_done;
	logic       tx_load;
	logic [7:0] rd_byte;
	logic       self_clr;

	assign reg_rst = reset | soft_rst_reg;

	// readback mux for the shift-out byte
	function automatic logic [7:0] read_mux(
		input logic [7:0] a,
		input logic [1:0] pg,
		input logic [7:0] ext,
		input logic [7:0] unl,
		input logic [4:0] fl
	);
		logic [7:0] v;
		v = 8'h00;
		if (a == `PIR_OFS_PAGE_UNLOCK) begin
			v = unl;
		end else if (a == `PIR_OFS_INT_FLAGS) begin
			v = {3'h0, fl};
		end else if (pg == `PIR_PG_LED && a >= `PIR_LED_RD_FIRST
				&& a <= `PIR_LED_RD_LAST) begin
			v = ext;
		end else if (pg == `PIR_PG_FUNC && a == `PIR_FUNC_RESET_OFS) begin
			v = ext;
		end
		return v;
	endfunction

	// own address from fixed top bits and strap codes
	assign addr_hit = rx_reg[7:1] == {`PIR_ADDR_TOP, strap_hi_s, strap_lo_s};
	// address acknowledged only on a match; later bytes always
	assign accept      = is_addr_reg ? addr_hit : 1'b1;
	assign byte_done   = fall_ev & (state_reg == pir_pkg::ST_RX) & (cnt_reg == 4'h8);
	assign ptr_load_ev = byte_done & ~is_addr_reg & ~have_ptr_reg;
	assign wr_data_ev  = byte_done & ~is_addr_reg & have_ptr_reg;
	assign tx_done     = fall_ev & (state_reg == pir_pkg::ST_TX) & (cnt_reg == 4'h8);
	// shift-out starts after address ack on read, or after master ack
	assign tx_load = fall_ev & (cnt_reg == 4'h1) &
		(((state_reg == pir_pkg::ST_ACK) & read_dir_reg) |
		 ((state_reg == pir_pkg::ST_RACK) & mack_reg));
	// only the listed locations return data, all else reads zero
	assign rd_byte = read_mux(ptr_reg, page_reg, page_rd_data, unlock_reg, flags_reg);

	// ==========================================================
	// protocol engine

	// start restarts address reception from any state; stop idles
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg    <= pir_pkg::ST_IDLE;
			cnt_reg      <= 4'h0;
			rx_reg       <= 8'h00;
			tx_reg       <= 8'h00;
			is_addr_reg  <= 1'b0;
			have_ptr_reg <= 1'b0;
			read_dir_reg <= 1'b0;
			mack_reg     <= 1'b0;
			sda_oe_n     <= 1'b1;
		end else if (start_ev) begin
			state_reg   <= pir_pkg::ST_RX;
			cnt_reg     <= 4'h0;
			is_addr_reg <= 1'b1;
			sda_oe_n    <= 1'b1;
		end else if (stop_ev) begin
			state_reg <= pir_pkg::ST_IDLE;
			sda_oe_n  <= 1'b1;
		end else begin
			case (state_reg)
				pir_pkg::ST_RX: begin
					// bytes arrive most significant bit first
					if (bit_ev) begin
						rx_reg  <= {rx_reg[6:0], rx_bit};
						cnt_reg <= cnt_reg + 4'h1;
					end
					if (byte_done) begin
						cnt_reg <= 4'h0;
						if (accept) begin
							// pull data low through the ninth pulse
							state_reg <= pir_pkg::ST_ACK;
							sda_oe_n  <= 1'b0;
						end else begin
							state_reg <= pir_pkg::ST_IDLE;
						end
						if (is_addr_reg) begin
							read_dir_reg <= rx_reg[0];
							have_ptr_reg <= have_ptr_reg & rx_reg[0];
						end else begin
							// first byte after write address is the pointer
							have_ptr_reg <= 1'b1;
						end
						is_addr_reg <= 1'b0;
					end
				end
				pir_pkg::ST_ACK: begin
					if (bit_ev) begin
						cnt_reg <= 4'h1;
					end
					if (fall_ev && cnt_reg == 4'h1) begin
						cnt_reg <= 4'h0;
						if (read_dir_reg) begin
							state_reg <= pir_pkg::ST_TX;
							sda_oe_n  <= rd_byte[7];
							tx_reg    <= {rd_byte[6:0], 1'b0};
						end else begin
							state_reg <= pir_pkg::ST_RX;
							sda_oe_n  <= 1'b1;
						end
					end
				end
				pir_pkg::ST_TX: begin
					if (bit_ev) begin
						cnt_reg <= cnt_reg + 4'h1;
					end
					// next bit goes out on each falling clock
					if (tx_done) begin
						state_reg <= pir_pkg::ST_RACK;
						cnt_reg   <= 4'h0;
						sda_oe_n  <= 1'b1;
					end else if (fall_ev && cnt_reg != 4'h0) begin
						sda_oe_n <= tx_reg[7];
						tx_reg   <= {tx_reg[6:0], 1'b0};
					end
				end
				pir_pkg::ST_RACK: begin
					// master low means another byte is wanted
					if (bit_ev) begin
						cnt_reg  <= 4'h1;
						mack_reg <= ~rx_bit;
					end
					if (fall_ev && cnt_reg == 4'h1) begin
						cnt_reg <= 4'h0;
						if (mack_reg) begin
							state_reg <= pir_pkg::ST_TX;
							sda_oe_n  <= rd_byte[7];
							tx_reg    <= {rd_byte[6:0], 1'b0};
						end else begin
							state_reg <= pir_pkg::ST_IDLE;
						end
					end
				end
				pir_pkg::ST_IDLE: cnt_reg <= 4'h0;
				default: begin
					state_reg <= pir_pkg::ST_IDLE;
					sda_oe_n  <= 1'b1;
				end
			endcase
		end
	end

	// open drain: the pin is only ever pulled low
	always_ff @(posedge core_clk) begin
		sda_out <= 1'b0;
	end

	// ==========================================================
	// register pointer

	// advance by one on each data ack and after each byte sent
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ptr_reg <= 8'h00;
		end else if (ptr_load_ev) begin
			ptr_reg <= rx_reg;
		end else if (wr_data_ev || tx_done) begin
			ptr_reg <= ptr_reg + 8'h01;
		end
	end

	assign page_rd = {page_reg, ptr_reg};

	// ==========================================================
	// command registers

	// page select writes honoured only while the key is held
	always_ff @(posedge core_clk) begin
		if (reg_rst) begin
			page_reg   <= `PIR_RST_PAGE_SEL;
			unlock_reg <= `PIR_RST_PAGE_UNLOCK;
			mask_reg   <= `PIR_RST_INT_MASK;
		end else if (wr_data_ev) begin
			case (ptr_reg)
				`PIR_OFS_PAGE_SEL: begin
					// reserved values leave the page unchanged
					if (unlock_reg == `PIR_UNLOCK_KEY && rx_reg <= `PIR_PAGE_MAX) begin
						page_reg <= rx_reg[1:0];
					end
					// the key is spent by any page select write
					if (unlock_reg == `PIR_UNLOCK_KEY) begin
						unlock_reg <= `PIR_RST_PAGE_UNLOCK;
					end
				end
				`PIR_OFS_PAGE_UNLOCK: begin
					unlock_reg <= rx_reg;
				end
				`PIR_OFS_INT_MASK: begin
					mask_reg <= rx_reg[3:0];
				end
				default: mask_reg <= mask_reg;
			endcase
		end
	end

	// other writes, except to the status register, go to the selected page bank
	always_ff @(posedge core_clk) begin
		if (reset) begin
			page_wr <= '0;
		end else begin
			page_wr.valid <= wr_data_ev && ptr_reg != `PIR_OFS_PAGE_SEL
				&& ptr_reg != `PIR_OFS_PAGE_UNLOCK && ptr_reg != `PIR_OFS_INT_MASK
				&& ptr_reg != `PIR_OFS_INT_FLAGS;
			page_wr.page  <= page_reg;
			page_wr.addr  <= ptr_reg;
			page_wr.data  <= rx_reg;
		end
	end

	// reading the function page reset location restores power-up values
	always_ff @(posedge core_clk) begin
		soft_rst_reg <= !reset && tx_load && page_reg == `PIR_PG_FUNC
			&& ptr_reg == `PIR_FUNC_RESET_OFS;
	end

	// ==========================================================
	// status flags and interrupt

	// sticky flags; a new event beats a read or self clear
	always_ff @(posedge core_clk) begin
		if (reg_rst) begin
			flags_reg <= `PIR_RST_INT_FLAGS;
		end else if ((tx_load && ptr_reg == `PIR_OFS_INT_FLAGS) || self_clr) begin
			flags_reg <= led_events;
		end else begin
			flags_reg <= flags_reg | led_events;
		end
	end

	// output low only for enabled flags
	always_ff @(posedge core_clk) begin
		if (reset) begin
			interrupt_out_n <= 1'b1;
		end else begin
			interrupt_out_n <= ~|(flags_reg & {{3{mask_reg[`PIR_MASK_BREATH]}},
				mask_reg[`PIR_MASK_SHORT], mask_reg[`PIR_MASK_OPEN]});
		end
	end

	// count low time; saturates so the clear fires on two cycles, until the output rises
	always_ff @(posedge core_clk) begin
		if (reset || interrupt_out_n || !mask_reg[`PIR_MASK_SELF_CLR]) begin
			low_cnt_reg <= 32'h0;
		end else if (low_cnt_reg != SELF_CLR_CYCLES) begin
			low_cnt_reg <= low_cnt_reg + 32'h1;
		end
	end

	assign self_clr = mask_reg[`PIR_MASK_SELF_CLR] & ~interrupt_out_n
		& (low_cnt_reg == SELF_CLR_CYCLES);

endmodule

`default_nettype wire

/* verif/paged_i2c_register_port_test.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bench top
module paged_i2c_register_port_test;
	localparam int SELF_CLR = 50;
	logic              core_clk = 1'b0;
	logic              reset = 1'b1;
	logic [1:0]        strap_lo = 2'h1;
	logic [1:0]        strap_hi = 2'h2;
	pir_pkg::pir_evt_t evt = '0;
	pir_pkg::pir_rd_t  prd;
	pir_pkg::pir_wr_t  pwr;
	logic [7:0]        rd_data;
	logic              int_n;
	logic              oe_n;
	logic              sda_o;
	wire logic         scl;
	wire logic         drv;
	wire logic         sda_line;
	logic [17:0]       wrq[$];
	int                miscompares = 0;
	int                check_count = 0;
	wire logic [6:0]   dev = {3'h5, strap_hi, strap_lo};

	always #10 core_clk = ~core_clk;

	// open drain with pull-up; page bank returns a known pattern
	assign sda_line = drv & (oe_n | sda_o);
	assign rd_data = prd.addr ^ 8'h5A;

	always @(posedge core_clk) begin
		if (pwr.valid === 1'b1)
			wrq.push_back({pwr.page, pwr.addr, pwr.data});
	end

	pir_port #(.SELF_CLR_CYCLES(SELF_CLR)) dut_u (
		.core_clk(core_clk),
		.reset(reset),
		.link_scl(scl),
		.sda_in(sda_line),
		.sda_out(sda_o),
		.sda_oe_n(oe_n),
		.address_strap_low(strap_lo),
		.address_strap_high(strap_hi),
		.led_events(evt),
		.page_rd_data(rd_data),
		.page_rd(prd),
		.page_wr(pwr),
		.interrupt_out_n(int_n)
	);

	pir_i2c_master mst_u (.sda_line(sda_line), .scl(scl), .sda_drv(drv));

	task automatic chk_bit(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t bit got %b exp %b", $time, g, e);
		end
	endtask

	task automatic chk_val(input logic [17:0] g, input logic [17:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t value got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_wr(input logic [17:0] e);
		chk_val((wrq.size() > 0) ? wrq.pop_front() : 18'h3FFFF, e);
	endtask

	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d, input int n);
		logic a;
		mst_u.start();
		mst_u.put_byte({dev, 1'b0}, a);
		chk_bit(a, 1'b0);
		mst_u.put_byte(ptr, a);
		chk_bit(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			mst_u.put_byte(d + 8'(i), a);
			chk_bit(a, 1'b0);
		end
		mst_u.stop();
	endtask

	// pointer write, repeated start, two bytes back
	task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] e0, input logic [7:0] e1);
		logic a;
		logic [7:0] d;
		mst_u.start();
		mst_u.put_byte({dev, 1'b0}, a);
		mst_u.put_byte(ptr, a);
		mst_u.start();
		mst_u.put_byte({dev, 1'b1}, a);
		chk_bit(a, 1'b0);
		mst_u.get_byte(1'b0, d);
		chk_val(18'(d), 18'(e0));
		mst_u.get_byte(1'b1, d);
		chk_val(18'(d), 18'(e1));
		mst_u.stop();
	endtask

	task automatic pulse(input logic [4:0] v);
		@(posedge core_clk);
		evt <= v;
		@(posedge core_clk);
		evt <= '0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic results();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		logic a;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		reg_rd(8'hFE, 8'h00, 8'h00);
		reg_rd(8'hF0, 8'h00, 8'h00);
		mst_u.start();
		mst_u.put_byte({dev ^ 7'h01, 1'b0}, a);
		chk_bit(a, 1'b1);
		mst_u.stop();
		reg_wr(8'h10, 8'hAA, 3);
		chk_wr({2'h0, 8'h10, 8'hAA});
		chk_wr({2'h0, 8'h11, 8'hAB});
		chk_wr({2'h0, 8'h12, 8'hAC});
		reg_wr(8'hFD, 8'h01, 1);
		reg_wr(8'h05, 8'h33, 1);
		chk_wr({2'h0, 8'h05, 8'h33});
		reg_wr(8'hFE, 8'hC5, 1);
		reg_rd(8'hFE, 8'hC5, 8'h00);
		reg_wr(8'hFD, 8'h01, 1);
		reg_rd(8'hFE, 8'h00, 8'h00);
		reg_wr(8'hFD, 8'h02, 1);
		reg_wr(8'h05, 8'h33, 1);
		chk_wr({2'h1, 8'h05, 8'h33});
		reg_rd(8'h20, 8'h00, 8'h00);
		reg_wr(8'hFE, 8'hC5, 1);
		reg_wr(8'hFD, 8'h00, 1);
		reg_rd(8'h17, 8'h00, 8'h42);
		reg_rd(8'h47, 8'h1D, 8'h00);
		reg_wr(8'hF0, 8'h02, 1);
		pulse(5'h01);
		chk_bit(int_n, 1'b1);
		reg_rd(8'hF1, 8'h01, 8'h00);
		pulse(5'h02);
		chk_bit(int_n, 1'b0);
		reg_rd(8'hF1, 8'h02, 8'h00);
		reg_wr(8'hF0, 8'h04, 1);
		pulse(5'h10);
		repeat (SELF_CLR + 30) @(posedge core_clk);
		chk_bit(int_n, 1'b0);
		reg_rd(8'hF1, 8'h10, 8'h00);
		reg_wr(8'hF0, 8'h0C, 1);
		pulse(5'h08);
		repeat (SELF_CLR - 5) @(posedge core_clk);
		chk_bit(int_n, 1'b0);
		for (int i = 0; i < 20 && int_n !== 1'b1; i++)
			@(posedge core_clk);
		chk_bit(int_n, 1'b1);
		reg_rd(8'hF1, 8'h00, 8'h00);
		// reserved page value spends the key but keeps the page
		reg_wr(8'hFE, 8'hC5, 1);
		reg_wr(8'hFD, 8'h07, 1);
		reg_rd(8'hFE, 8'h00, 8'h00);
		reg_wr(8'h05, 8'h55, 1);
		chk_wr({2'h0, 8'h05, 8'h55});
		// function page reset location restores power-up values
		reg_wr(8'hFE, 8'hC5, 1);
		reg_wr(8'hFD, 8'h03, 1);
		reg_rd(8'h11, 8'h4B, 8'h00);
		pulse(5'h10);
		chk_bit(int_n, 1'b1);
		reg_wr(8'h05, 8'h66, 1);
		chk_wr({2'h0, 8'h05, 8'h66});
		reg_rd(8'hF1, 8'h10, 8'h00);
		chk_val(18'(wrq.size()), 18'h0);
		results();
	end
endmodule

bind pir_port pir_port_checker #(.SELF_CLR_CYCLES(SELF_CLR_CYCLES)) chk_u (
	.core_clk(core_clk),
	.reset(reset),
	.link_scl(link_scl),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe_n(sda_oe_n),
	.address_strap_low(address_strap_low),
	.address_strap_high(address_strap_high),
	.led_events(led_events),
	.page_rd_data(page_rd_data),
	.page_rd(page_rd),
	.page_wr(page_wr),
	.interrupt_out_n(interrupt_out_n)
);
`default_nettype wire

/* verif/pir_i2c_master.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bus master model, runs on its own link tick
module pir_i2c_master (
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic sda_drv
);
	logic lclk = 1'b0;

	// 30 ns tick, unrelated to the core clock
	always #15 lclk = ~lclk;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge lclk);
	endtask

	// start, also used as repeated start
	task automatic start();
		sda_drv <= 1'b1;
		wt(5);
		scl <= 1'b1;
		wt(10);
		sda_drv <= 1'b0;
		wt(10);
		scl <= 1'b0;
		wt(5);
	endtask

	task automatic stop();
		sda_drv <= 1'b0;
		wt(5);
		scl <= 1'b1;
		wt(10);
		sda_drv <= 1'b1;
		wt(10);
	endtask

	// data moves only while scl low, sampled mid high
	task automatic bit_io(input logic b, output logic got);
		sda_drv <= b;
		wt(5);
		scl <= 1'b1;
		wt(5);
		got = sda_line;
		wt(5);
		scl <= 1'b0;
		wt(5);
	endtask

	// msb first, line released for acknowledge
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], g);
		bit_io(1'b1, ack);
	endtask

	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, g);
	endtask
endmodule
`default_nettype wire

/* verif/pir_port_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// port checker, sees the top ports only
module pir_port_checker #(
	parameter int unsigned SELF_CLR_CYCLES = 400000
) (
	input wire logic              core_clk,
	input wire logic              reset,
	input wire logic              link_scl,
	input wire logic              sda_in,
	input wire logic              sda_out,
	input wire logic              sda_oe_n,
	input wire logic [1:0]        address_strap_low,
	input wire logic [1:0]        address_strap_high,
	input wire pir_pkg::pir_evt_t led_events,
	input wire logic [7:0]        page_rd_data,
	input wire pir_pkg::pir_rd_t  page_rd,
	input wire pir_pkg::pir_wr_t  page_wr,
	input wire logic              interrupt_out_n
);
	logic [7:0] nxt_ptr_reg;
	logic       evt_any;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// any event input active, for the cause check
	assign evt_any = |led_events;

	// pointer expected once a stored byte is acknowledged
	always_ff @(posedge core_clk) begin
		if (page_wr.valid)
			nxt_ptr_reg <= page_wr.addr + 8'h01;
	end

	AST_SDA_PULL_ONLY: assert property (sda_out == 1'b0)
		else $error("sda_out drove high");
	AST_RESET_QUIET: assert property (@(posedge core_clk) disable iff (1'b0)
		reset |=> sda_oe_n && interrupt_out_n && !page_wr.valid)
		else $error("outputs active after reset");
	AST_WR_ONE_PULSE: assert property (page_wr.valid |=> !page_wr.valid)
		else $error("store pulse longer than a cycle");
	AST_WR_NOT_CMD: assert property (page_wr.valid |->
		!(page_wr.addr inside {8'hF0, 8'hF1, 8'hFD, 8'hFE}))
		else $error("command offset sent to page banks");
	AST_WR_PAGE: assert property (page_wr.valid |-> page_wr.page == page_rd.page)
		else $error("store page differs from selected page");
	AST_PTR_STEP: assert property (page_wr.valid |=> ##[0:3] page_rd.addr == nxt_ptr_reg)
		else $error("pointer did not advance by one");
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !link_scl)
		else $error("data drive changed while scl high");
	AST_INT_CAUSE: assert property ($fell(interrupt_out_n) |->
		$past(evt_any, 2) || $past(evt_any, 3))
		else $error("interrupt without an event");
	AST_INT_HOLDS: assert property ($fell(interrupt_out_n) |=> (!interrupt_out_n) [*8])
		else $error("interrupt released early");

	COV_STORE: cover property (page_wr.valid);
	COV_INT_SET: cover property ($fell(interrupt_out_n));
	COV_INT_CLR: cover property ($rose(interrupt_out_n));
endmodule
`default_nettype wire
